// File: config_loader_defs.vh
// Purpose: Shared constants for the configuration programming control block
// Assumes: Included by bare name from the design files
// Notes: Pin order in the synchroniser vector is fixed here
`ifndef CONFIG_LOADER_DEFS_VH
`define CONFIG_LOADER_DEFS_VH

// Master clock divider, half period of the generated SPI clock
`define DIV_W 3
`define SCK_HALF_CYC 3'h7

// Flash read command and image locations
`define FLASH_READ_CMD 8'h03
`define PRIMARY_ADDR 24'h00_1000
`define GOLDEN_ADDR 24'h10_0000
`define CMD_BITS 6'h20
`define CMD_MSB 31
`define BYTE_LAST_BIT 3'h7

// Image header byte layout
`define HDR_ENC_BIT 7
`define HDR_VER_MSB 6

// Stream phase index
`define IDX_HDR 2'h0
`define IDX_LEN 2'h1
`define IDX_DATA 2'h2

// Length byte values of interest
`define LEN_ZERO 8'h00
`define LEN_LAST 8'h01

// Session source codes
`define SRC_NONE 2'h0
`define SRC_MASTER 2'h1
`define SRC_SLAVE 2'h2
`define SRC_JTAG 2'h3

// Straps are caught one cycle after the counter reaches this value after reset release
`define BOOT_WAIT 2'h3

// Pin synchroniser vector: trst, tristate, mode, miso, mosi, ss, clk
`define PIN_N 7
`define PIN_RST 7'h02
`define PIN_CLK 0
`define PIN_SS 1
`define PIN_MOSI 2
`define PIN_MISO 3
`define PIN_MODE 4
`define PIN_TRI 5
`define PIN_TRST 6

// Stream buffer shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4

`define DIGEST_REGIONS 5

`endif

// File: stream_fifo.v
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes: Full and empty come from an occupancy count
`default_nettype none

module stream_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	localparam [AW:0] FULL = DEPTH[AW:0];
	localparam [AW:0] EMPTY = {(AW+1){1'b0}};

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr;
	reg [AW-1:0] rd;
	reg [AW:0] cnt;
	wire push;
	wire pop;

	// Handshakes and honest full/empty
	assign in_ready = (cnt != FULL);
	assign out_valid = (cnt != EMPTY);
	assign out_data = mem[rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage write
	always @(posedge clk)
	begin
		if (push)
			mem[wr] <= in_data;
	end

	// Pointers and occupancy
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr <= {AW{1'b0}};
			rd <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr <= wr + 1'b1;
			if (pop)
				rd <= rd + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end

endmodule // stream_fifo

`default_nettype wire

// File: config_programming_control.v
// Purpose: Configuration programming and protection control
// Assumes: Bitstream bytes: header, length, then data bytes
// Notes: SPI pins are sampled on SYS_CLK; the SPI clock is a plain input
`include "config_loader_defs.vh"
`default_nettype none

module config_programming_control (
	// Clock and reset
	input wire SYS_CLK,
	input wire RESET_N,
	// Dedicated SPI pins
	input wire SPI_CLK_I,
	output reg SPI_CLK_O,
	output reg SPI_CLK_OE,
	input wire SPI_SS_N_I,
	output reg SPI_SS_N_O,
	output reg SPI_SS_N_OE,
	input wire SPI_MOSI_I,
	output reg SPI_MOSI_O,
	output reg SPI_MOSI_OE,
	input wire SPI_MISO_I,
	output reg SPI_MISO_O,
	output reg SPI_MISO_OE,
	// Dedicated SPI mode and enable pins
	input wire SPI_MODE_MASTER,
	input wire SPI_TRISTATE,
	// JTAG side
	input wire JTAG_TRST_N,
	input wire JTAG_UNSUSPEND,
	input wire [7:0] JTAG_DATA,
	input wire JTAG_VALID,
	output wire JTAG_READY,
	// Non-volatile settings and power-up status
	input wire SUSPEND_NV,
	input wire AUTO_UPDATE_EN,
	input wire DEVICE_BLANK,
	input wire RECOVERY_PENDING,
	input wire [6:0] CURRENT_VERSION,
	// User SPI access primitive
	input wire USER_SPI_REQ,
	input wire USER_SPI_CLK,
	input wire USER_SPI_SS_N,
	input wire USER_SPI_MOSI,
	output reg USER_SPI_MISO,
	output wire USER_SPI_GRANT,
	// Configuration array write port
	output wire [7:0] PROG_DATA,
	output wire PROG_VALID,
	input wire PROG_READY,
	// Programming status
	output wire PROG_BUSY,
	output reg PROG_DONE,
	output reg PROG_REJECT,
	output reg SLAVE_OVERRUN,
	output wire SUSPEND_ACTIVE,
	output wire CTRL_HALTED,
	// Integrity
	input wire [`DIGEST_REGIONS-1:0] DIGEST_FAIL,
	input wire DIGEST_CLEAR,
	output reg DIGEST_TAMPER
);

	localparam [3:0] M_IDLE = 4'h1;
	localparam [3:0] M_CMD = 4'h2;
	localparam [3:0] M_READ = 4'h4;
	localparam [3:0] M_DONE = 4'h8;
	localparam [7:0] READ_CMD = `FLASH_READ_CMD;

	// Majority of three latch copies
	function vote3;
		input [2:0] v;
		begin
			vote3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
		end
	endfunction

	// Header accept: encrypted, and newer when asked
	function hdr_accept;
		input [7:0] b;
		input newer_only;
		input [6:0] cur;
		begin
			hdr_accept = b[`HDR_ENC_BIT] &&
				(!newer_only || (b[`HDR_VER_MSB:0] > cur));
		end
	endfunction

	reg rst_s1;
	reg rst_n;
	reg [`PIN_N-1:0] pin_m;
	reg [`PIN_N-1:0] pin_s;
	reg clk_d;
	reg ss_d;
	reg [1:0] boot_cnt;
	reg strap_done;
	reg mode_master;
	reg boot_pend;
	reg [2:0] triple_redundant_latch;
	reg [`DIV_W-1:0] div;
	reg [3:0] mst;
	reg sck;
	reg ss_n;
	reg mosi;
	reg [`CMD_MSB:0] cmd_sr;
	reg [5:0] bitcnt;
	reg [7:0] rx;
	reg m_stb;
	reg [7:0] m_byte;
	reg newer_only;
	reg [7:0] s_sr;
	reg [2:0] s_cnt;
	reg s_stb;
	reg [7:0] s_byte;
	reg [1:0] sess_src;
	reg [1:0] idx;
	reg [7:0] remain;
	reg skip;

	wire clk_s = pin_s[`PIN_CLK];
	wire ss_s = pin_s[`PIN_SS];
	wire mosi_s = pin_s[`PIN_MOSI];
	wire miso_s = pin_s[`PIN_MISO];
	wire tri_s = pin_s[`PIN_TRI];
	wire suspended = vote3(triple_redundant_latch);
	wire tick = (div == `SCK_HALF_CYC);
	wire may_run = !suspended && !tri_s;
	wire fifo_ready;
	wire boot_go = (mst == M_IDLE) && boot_pend && may_run;
	wire m_start = boot_go && mode_master &&
		(RECOVERY_PENDING || DEVICE_BLANK || AUTO_UPDATE_EN);
	wire m_active = (mst == M_CMD) || (mst == M_READ);
	wire slave_on = strap_done && !mode_master && may_run;
	wire s_ok = s_stb && ((sess_src == `SRC_NONE) ||
		(sess_src == `SRC_SLAVE));
	wire s_end = (sess_src == `SRC_SLAVE) && ss_s && !ss_d;
	wire j_stb = JTAG_VALID && JTAG_READY;
	wire any_stb = m_stb || s_ok || j_stb;
	wire [7:0] any_byte = m_stb ? m_byte : (s_ok ? s_byte : JTAG_DATA);
	wire [1:0] stb_src = m_stb ? `SRC_MASTER :
		(s_ok ? `SRC_SLAVE : `SRC_JTAG);
	wire hdr_ok = hdr_accept(any_byte, newer_only && m_stb,
		CURRENT_VERSION);
	wire sess_end = any_stb && (((idx == `IDX_HDR) && !hdr_ok) ||
		((idx == `IDX_LEN) && (any_byte == `LEN_ZERO)) ||
		((idx == `IDX_DATA) && (remain == `LEN_LAST)));
	wire push = any_stb && (idx == `IDX_DATA) && !skip;
	wire ctrl_own = m_active || (sess_src == `SRC_SLAVE);

	// JTAG bytes only when idle or own session, never while suspended
	assign JTAG_READY = strap_done && !suspended && fifo_ready &&
		((sess_src == `SRC_NONE) || (sess_src == `SRC_JTAG));
	assign USER_SPI_GRANT = USER_SPI_REQ && !tri_s && !ctrl_own;
	assign PROG_BUSY = (sess_src != `SRC_NONE);
	assign SUSPEND_ACTIVE = suspended;
	assign CTRL_HALTED = suspended || !strap_done;

	// Reset release through two flip-flops
	always @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Pin synchronisers and edge history
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_m <= `PIN_RST;
			pin_s <= `PIN_RST;
			clk_d <= 1'b0;
			ss_d <= 1'b1;
		end
		else
		begin
			pin_m <= {JTAG_TRST_N, SPI_TRISTATE, SPI_MODE_MASTER,
				SPI_MISO_I, SPI_MOSI_I, SPI_SS_N_I, SPI_CLK_I};
			pin_s <= pin_m;
			clk_d <= clk_s;
			ss_d <= ss_s;
		end
	end

	// Straps and the redundant suspend latch
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			boot_cnt <= 2'h0;
			strap_done <= 1'b0;
			mode_master <= 1'b0;
			boot_pend <= 1'b0;
			triple_redundant_latch <= 3'h0;
		end
		else
		begin
			if (boot_cnt != `BOOT_WAIT)
				boot_cnt <= boot_cnt + 1'b1;
			if (boot_cnt == `BOOT_WAIT && !strap_done)
			begin
				strap_done <= 1'b1;
				mode_master <= pin_s[`PIN_MODE];
				boot_pend <= 1'b1;
				triple_redundant_latch <= {3{SUSPEND_NV}};
			end
			else if (pin_s[`PIN_TRST] && JTAG_UNSUSPEND)
				triple_redundant_latch <= 3'h0;
			else
				triple_redundant_latch <= {3{suspended}};
			if (boot_go)
				boot_pend <= 1'b0;
		end
	end

	// SPI clock divider enable
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			div <= {`DIV_W{1'b0}};
		else
			div <= tick ? {`DIV_W{1'b0}} : div + 1'b1;
	end

	// Master flash fetch at power-up
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mst <= M_IDLE;
			sck <= 1'b0;
			ss_n <= 1'b1;
			mosi <= 1'b0;
			cmd_sr <= 32'h0000_0000;
			bitcnt <= 6'h00;
			rx <= 8'h00;
			m_stb <= 1'b0;
			m_byte <= 8'h00;
			newer_only <= 1'b0;
		end
		else
		begin
			m_stb <= 1'b0;
			case (mst)
			M_IDLE:
			begin
				if (boot_go && !m_start)
					mst <= M_DONE;
				else if (m_start)
				begin
					mst <= M_CMD;
					ss_n <= 1'b0;
					bitcnt <= 6'h00;
					newer_only <= AUTO_UPDATE_EN && !DEVICE_BLANK &&
						!RECOVERY_PENDING;
					// Command goes out MSB first
					mosi <= READ_CMD[`BYTE_LAST_BIT];
					if (RECOVERY_PENDING)
						cmd_sr <= {`FLASH_READ_CMD, `GOLDEN_ADDR};
					else
						cmd_sr <= {`FLASH_READ_CMD, `PRIMARY_ADDR};
				end
			end
			M_CMD:
			begin
				if (tick && may_run)
				begin
					if (!sck)
					begin
						sck <= 1'b1;
						bitcnt <= bitcnt + 1'b1;
					end
					else if (bitcnt == `CMD_BITS)
					begin
						sck <= 1'b0;
						mst <= M_READ;
						bitcnt <= 6'h00;
					end
					else
					begin
						sck <= 1'b0;
						mosi <= cmd_sr[`CMD_MSB-1];
						cmd_sr <= {cmd_sr[`CMD_MSB-1:0], 1'b0};
					end
				end
			end
			M_READ:
			begin
				if (sess_end)
				begin
					mst <= M_DONE;
					ss_n <= 1'b1;
					sck <= 1'b0;
				end
				// Hold the clock low while the buffer is full
				else if (tick && may_run && (sck || fifo_ready))
				begin
					sck <= !sck;
					if (!sck)
					begin
						rx <= {rx[6:0], miso_s};
						bitcnt <= bitcnt + 1'b1;
						if (bitcnt[2:0] == `BYTE_LAST_BIT)
						begin
							m_stb <= 1'b1;
							m_byte <= {rx[6:0], miso_s};
						end
					end
				end
			end
			M_DONE:
				mst <= M_DONE;
			default:
				mst <= M_IDLE;
			endcase
		end
	end

	// Slave byte capture on sampled clock rises
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_sr <= 8'h00;
			s_cnt <= 3'h0;
			s_stb <= 1'b0;
			s_byte <= 8'h00;
		end
		else
		begin
			s_stb <= 1'b0;
			if (!slave_on || ss_s)
				s_cnt <= 3'h0;
			else if (clk_s && !clk_d)
			begin
				s_sr <= {s_sr[6:0], mosi_s};
				s_cnt <= s_cnt + 1'b1;
				if (s_cnt == `BYTE_LAST_BIT)
				begin
					s_stb <= 1'b1;
					s_byte <= {s_sr[6:0], mosi_s};
				end
			end
		end
	end

	// Session: header check, length, data into the buffer
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sess_src <= `SRC_NONE;
			idx <= `IDX_HDR;
			remain <= 8'h00;
			skip <= 1'b0;
			PROG_DONE <= 1'b0;
			PROG_REJECT <= 1'b0;
			SLAVE_OVERRUN <= 1'b0;
		end
		else
		begin
			if (m_start || (any_stb && sess_src == `SRC_NONE))
			begin
				PROG_DONE <= 1'b0;
				PROG_REJECT <= 1'b0;
				SLAVE_OVERRUN <= 1'b0;
				skip <= 1'b0;
				sess_src <= m_start ? `SRC_MASTER : stb_src;
			end
			if (push && !fifo_ready)
				SLAVE_OVERRUN <= 1'b1;
			if (s_end)
			begin
				sess_src <= `SRC_NONE;
				idx <= `IDX_HDR;
				if (idx != `IDX_HDR)
					PROG_REJECT <= 1'b1;
			end
			else if (sess_end)
			begin
				sess_src <= `SRC_NONE;
				idx <= `IDX_HDR;
				if (idx == `IDX_HDR && !any_byte[`HDR_ENC_BIT])
					PROG_REJECT <= 1'b1;
				else if (idx != `IDX_HDR)
					PROG_DONE <= 1'b1;
			end
			else if (any_stb)
			begin
				if (idx == `IDX_HDR)
					idx <= `IDX_LEN;
				else if (idx == `IDX_LEN)
				begin
					idx <= `IDX_DATA;
					remain <= any_byte;
				end
				else
					remain <= remain - 1'b1;
			end
		end
	end

	// Pin drivers: controller, user primitive, or released
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			SPI_CLK_O <= 1'b0;
			SPI_CLK_OE <= 1'b0;
			SPI_SS_N_O <= 1'b1;
			SPI_SS_N_OE <= 1'b0;
			SPI_MOSI_O <= 1'b0;
			SPI_MOSI_OE <= 1'b0;
			SPI_MISO_O <= 1'b0;
			SPI_MISO_OE <= 1'b0;
			USER_SPI_MISO <= 1'b0;
		end
		else
		begin
			SPI_CLK_O <= USER_SPI_GRANT ? USER_SPI_CLK : sck;
			SPI_SS_N_O <= USER_SPI_GRANT ? USER_SPI_SS_N : ss_n;
			SPI_MOSI_O <= USER_SPI_GRANT ? USER_SPI_MOSI : mosi;
			SPI_CLK_OE <= !tri_s && (USER_SPI_GRANT || m_active);
			SPI_SS_N_OE <= !tri_s && (USER_SPI_GRANT || m_active);
			SPI_MOSI_OE <= !tri_s && (USER_SPI_GRANT || m_active);
			SPI_MISO_O <= 1'b0;
			SPI_MISO_OE <= 1'b0;
			USER_SPI_MISO <= miso_s;
		end
	end

	// Sticky tamper flag, a new mismatch beats the clear
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			DIGEST_TAMPER <= 1'b0;
		else if (|DIGEST_FAIL)
			DIGEST_TAMPER <= 1'b1;
		else if (DIGEST_CLEAR)
			DIGEST_TAMPER <= 1'b0;
	end

	// Decrypted-side buffer toward the configuration array
	stream_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(any_byte),
		.out_valid(PROG_VALID),
		.out_ready(PROG_READY),
		.out_data(PROG_DATA)
	);

endmodule // config_programming_control

`default_nettype wire

// File: config_programming_control_asserts.sv
// Purpose: Port-level checks for the configuration programming control
// Assumes: Bound to the top module, pins synchronised within six cycles
// Notes: All checks share the system clock domain
`include "config_loader_defs.vh"
`default_nettype none
module config_programming_control_asserts (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Dedicated SPI pins and user access
	input wire logic SPI_TRISTATE,
	input wire logic SPI_CLK_OE,
	input wire logic SPI_SS_N_OE,
	input wire logic SPI_MOSI_OE,
	input wire logic SPI_MISO_OE,
	input wire logic USER_SPI_GRANT,
	// JTAG and suspend
	input wire logic JTAG_TRST_N,
	input wire logic JTAG_READY,
	input wire logic SUSPEND_ACTIVE,
	input wire logic CTRL_HALTED,
	// Stream and integrity
	input wire logic PROG_VALID,
	input wire logic PROG_READY,
	input wire logic [7:0] PROG_DATA,
	input wire logic [`DIGEST_REGIONS-1:0] DIGEST_FAIL,
	input wire logic DIGEST_CLEAR,
	input wire logic DIGEST_TAMPER
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// Pin release and sharing
	a_tri_releases: assert property (
		SPI_TRISTATE [*6] |-> !(SPI_CLK_OE || SPI_SS_N_OE || SPI_MOSI_OE))
		else $error("pin driven while released");
	a_miso_input: assert property (!SPI_MISO_OE)
		else $error("data-in pin driven");
	a_tri_no_grant: assert property (
		SPI_TRISTATE [*6] |-> !USER_SPI_GRANT)
		else $error("user granted while released");
	// Suspend behaviour
	a_suspend_refuses: assert property (
		SUSPEND_ACTIVE |-> !JTAG_READY)
		else $error("stream taken while suspended");
	a_suspend_halts: assert property (
		SUSPEND_ACTIVE |-> CTRL_HALTED)
		else $error("controller runs while suspended");
	a_trst_holds: assert property (
		(!JTAG_TRST_N [*4]) ##0 SUSPEND_ACTIVE |=> SUSPEND_ACTIVE)
		else $error("suspend left with trst low");
	// Tamper flag
	a_tamper_sets: assert property (
		$past(RESET_N, 3) && (|DIGEST_FAIL) |=> DIGEST_TAMPER)
		else $error("digest failure not flagged");
	a_tamper_sticks: assert property (
		DIGEST_TAMPER && !DIGEST_CLEAR |=> DIGEST_TAMPER)
		else $error("tamper flag lost");
	// Stalled stream output
	a_data_holds: assert property (
		PROG_VALID && !PROG_READY |=> PROG_VALID && $stable(PROG_DATA))
		else $error("stalled byte changed");
endmodule // config_programming_control_asserts
`default_nettype wire

// File: spi_master_model.sv
// Purpose: External SPI master streaming a bitstream into the slave port
// Assumes: Mode 0, MSB first, 125 ns clock period
// Notes: Clock rests low between frames; data turns over once released
`default_nettype none
module spi_master_model (
	// Lines toward the device
	output var logic sclk,
	output var logic ss_n,
	output var logic mosi
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus, select pulled high
	initial
	begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// One framed transfer, master drives every bit
	task automatic send(input logic [23:0] bits, input int nbits);
		int i;
		ss_n = 1'b0;
		for (i = nbits - 1; i >= 0; i--)
		begin
			mosi = bits[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 ss_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule // spi_master_model
`default_nettype wire

// File: config_programming_control_tb.sv
// Purpose: Self-checking bench for config_programming_control
// Assumes: Flash data-in low outside the master tests, user pin side idle
// Notes: Each boot re-samples the straps
`include "config_loader_defs.vh"
`default_nettype none
module config_programming_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic SYS_CLK = 1'b0, RESET_N = 1'b0, SPI_MODE_MASTER = 1'b0;
	logic SPI_TRISTATE = 1'b0, JTAG_TRST_N = 1'b1, JTAG_UNSUSPEND = 1'b0;
	logic JTAG_VALID = 1'b0, SUSPEND_NV = 1'b0, AUTO_UPDATE_EN = 1'b0;
	logic DEVICE_BLANK = 1'b0, RECOVERY_PENDING = 1'b0, USER_SPI_REQ = 1'b0;
	logic PROG_READY = 1'b1, DIGEST_CLEAR = 1'b0, flash_miso = 1'b0, ok;
	logic [7:0] JTAG_DATA = 8'h00;
	logic [6:0] CURRENT_VERSION = 7'h05;
	logic [4:0] DIGEST_FAIL = 5'h00;
	logic [7:0] got[$];
	int failures = 0, total_checks = 0;
	wire logic SPI_CLK_O, SPI_CLK_OE, SPI_SS_N_O, SPI_SS_N_OE, SPI_MOSI_O;
	wire logic SPI_MOSI_OE, SPI_MISO_OE, JTAG_READY, USER_SPI_GRANT;
	wire logic PROG_VALID, PROG_DONE, PROG_REJECT, SUSPEND_ACTIVE;
	wire logic CTRL_HALTED, DIGEST_TAMPER, m_sclk, m_ss_n, m_mosi;
	wire logic PROG_BUSY, SLAVE_OVERRUN, USER_SPI_MISO;
	wire logic [7:0] PROG_DATA;
	// Pin levels from whichever side drives
	wire logic clk_pin = SPI_CLK_OE ? SPI_CLK_O : m_sclk;
	wire logic ss_pin = SPI_SS_N_OE ? SPI_SS_N_O : m_ss_n;
	wire logic mosi_pin = SPI_MOSI_OE ? SPI_MOSI_O : m_mosi;
	// Device and far-side master
	config_programming_control u_config_programming_control (.SYS_CLK,
		.RESET_N, .SPI_CLK_I(clk_pin), .SPI_CLK_O, .SPI_CLK_OE,
		.SPI_SS_N_I(ss_pin), .SPI_SS_N_O, .SPI_SS_N_OE,
		.SPI_MOSI_I(mosi_pin), .SPI_MOSI_O, .SPI_MOSI_OE,
		.SPI_MISO_I(flash_miso), .SPI_MISO_O(), .SPI_MISO_OE,
		.SPI_MODE_MASTER, .SPI_TRISTATE, .JTAG_TRST_N, .JTAG_UNSUSPEND,
		.JTAG_DATA,
		.JTAG_VALID, .JTAG_READY, .SUSPEND_NV, .AUTO_UPDATE_EN,
		.DEVICE_BLANK, .RECOVERY_PENDING, .CURRENT_VERSION, .USER_SPI_REQ,
		.USER_SPI_CLK(1'b0), .USER_SPI_SS_N(1'b1), .USER_SPI_MOSI(1'b0),
		.USER_SPI_MISO, .USER_SPI_GRANT, .PROG_DATA, .PROG_VALID,
		.PROG_READY, .PROG_BUSY, .PROG_DONE, .PROG_REJECT,
		.SLAVE_OVERRUN, .SUSPEND_ACTIVE, .CTRL_HALTED, .DIGEST_FAIL,
		.DIGEST_CLEAR, .DIGEST_TAMPER);
	spi_master_model u_spi_master_model (.sclk(m_sclk), .ss_n(m_ss_n),
		.mosi(m_mosi));
	// Clock
	always #5 SYS_CLK = ~SYS_CLK;
	// Bytes taken by the array side
	always @(posedge SYS_CLK)
	begin
		if (PROG_VALID === 1'b1 && PROG_READY === 1'b1)
			got.push_back(PROG_DATA);
	end
	// Verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Compare and wait guard
	task automatic chk(input logic [31:0] g, e, input string m);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic guard(input logic c);
		if (c !== 1'b1)
		begin
			failures++;
			$display("mismatch at %0t: wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask
	// Reset with straps {mode, suspend, blank, recovery, update}
	task automatic boot(input logic [4:0] cfg);
		RESET_N = 1'b0;
		{SPI_MODE_MASTER, SUSPEND_NV, DEVICE_BLANK, RECOVERY_PENDING,
			AUTO_UPDATE_EN} = cfg;
		tick(3);
		chk({SPI_CLK_OE, SPI_SS_N_OE, SPI_MOSI_OE, SPI_SS_N_O, CTRL_HALTED},
			5'h03, "reset pins");
		RESET_N = 1'b1;
		tick(10);
		got.delete();
	endtask
	// JTAG byte handshake, valid left up
	task automatic jsend(input logic [7:0] b, output logic acc);
		int i;
		JTAG_DATA = b;
		JTAG_VALID = 1'b1;
		for (i = 0; i < 40 && JTAG_READY !== 1'b1; i++)
			tick();
		acc = JTAG_READY;
		if (acc === 1'b1)
			tick();
	endtask
	task automatic jseq(input logic [31:0] w, input int n);
		int i;
		for (i = n - 1; i >= 0; i--)
		begin
			jsend(w[i*8 +: 8], ok);
			guard(ok);
		end
		JTAG_VALID = 1'b0;
	endtask
	// JTAG image, then an unencrypted one
	task automatic t_jtag();
		boot(5'h00);
		chk(CTRL_HALTED, 1'b0, "halted after boot");
		jseq(32'h8102_A53C, 4);
		tick(2);
		chk({got[0], got[1], PROG_DONE}, 17'h1_4A79, "jtag image");
		jseq(32'h0000_0001, 1);
		tick(2);
		chk({PROG_REJECT, PROG_DONE}, 2'h2, "plain image");
	endtask
	// Fill the buffer with the array stalled, then drain
	task automatic t_fifo();
		int i, r;
		r = 0;
		PROG_READY = 1'b0;
		got.delete();
		jsend(8'h81, ok);
		guard(ok);
		jsend(8'h14, ok);
		guard(ok);
		for (i = 0; i < 20; i++)
		begin
			jsend(i[7:0], ok);
			if (ok !== 1'b1)
			begin
				r = i;
				PROG_READY = 1'b1;
				tick();
				jsend(i[7:0], ok);
				guard(ok);
			end
		end
		JTAG_VALID = 1'b0;
		tick(20);
		chk(r, 16, "buffer refusal");
		chk(got.size(), 20, "drained count");
		for (i = 0; i < 20; i++)
			chk(got[i], i, "drained order");
		chk(PROG_VALID, 1'b0, "buffer empty");
	endtask
	// Slave image, refused while released, then user grant
	task automatic t_slave();
		boot(5'h00);
		u_spi_master_model.send(24'h8201_C3, 24);
		tick(8);
		chk({got[0], PROG_DONE, SLAVE_OVERRUN}, 10'h30E,
			"slave image");
		u_spi_master_model.send(24'h00_8105, 16);
		tick(8);
		chk({PROG_REJECT, PROG_DONE}, 2'h2, "cut image");
		SPI_TRISTATE = 1'b1;
		USER_SPI_REQ = 1'b1;
		tick(8);
		chk({SPI_CLK_OE, SPI_SS_N_OE, SPI_MOSI_OE, USER_SPI_GRANT},
			4'h0, "released pins");
		u_spi_master_model.send(24'h8201_5A, 24);
		tick(8);
		chk(got.size(), 1, "ignored while released");
		SPI_TRISTATE = 1'b0;
		tick(6);
		chk({USER_SPI_GRANT, SPI_SS_N_OE}, 2'h3, "user grant");
		USER_SPI_REQ = 1'b0;
	endtask
	// Suspend held by trst, released by unsuspend
	task automatic t_susp();
		JTAG_TRST_N = 1'b0;
		boot(5'h08);
		chk({SUSPEND_ACTIVE, CTRL_HALTED, JTAG_READY}, 3'h6, "held");
		JTAG_UNSUSPEND = 1'b1;
		tick(6);
		chk(SUSPEND_ACTIVE, 1'b1, "held by trst");
		JTAG_TRST_N = 1'b1;
		tick(6);
		JTAG_UNSUSPEND = 1'b0;
		chk(SUSPEND_ACTIVE, 1'b0, "released");
		jseq(32'h0000_8100, 2);
		tick(2);
		chk(PROG_DONE, 1'b1, "program after release");
	endtask
	// Each digest region raises and clears the flag
	task automatic t_tamper();
		int i;
		for (i = 0; i < `DIGEST_REGIONS; i++)
		begin
			DIGEST_FAIL = 5'h01 << i;
			tick();
			DIGEST_FAIL = 5'h00;
			tick();
			chk(DIGEST_TAMPER, 1'b1, "tamper raised");
			DIGEST_CLEAR = 1'b1;
			tick();
			DIGEST_CLEAR = 1'b0;
			tick();
			chk(DIGEST_TAMPER, 1'b0, "tamper cleared");
		end
		// Mismatch and clear together
		DIGEST_FAIL = 5'h10;
		DIGEST_CLEAR = 1'b1;
		tick();
		DIGEST_FAIL = 5'h00;
		DIGEST_CLEAR = 1'b0;
		tick();
		chk(DIGEST_TAMPER, 1'b1, "set beats clear");
	endtask
	// Master boot, held off while released, then command and image
	task automatic t_master(input logic [4:0] cfg, input logic [31:0] exp,
		input logic [23:0] img, input int nbits, input logic done);
		int i, j;
		logic [31:0] cmd;
		SPI_TRISTATE = 1'b1;
		boot(cfg);
		tick(40);
		chk(SPI_SS_N_OE, 1'b0, "access while released");
		SPI_TRISTATE = 1'b0;
		for (j = 0; j < 60 && SPI_SS_N_OE !== 1'b1; j++)
			tick();
		guard(SPI_SS_N_OE);
		chk({SPI_SS_N_O, PROG_BUSY}, 2'h1, "flash selected");
		for (i = 31; i >= 0; i--)
		begin
			for (j = 0; j < 40 && SPI_CLK_O !== 1'b0; j++)
				tick();
			for (j = 0; j < 40 && SPI_CLK_O !== 1'b1; j++)
				tick();
			guard(SPI_CLK_O);
			cmd[i] = mosi_pin;
		end
		chk(cmd, exp, "flash read command");
		// Flash shifts each bit out after a falling clock
		for (i = nbits - 1; i >= 0; i--)
		begin
			for (j = 0; j < 40 && SPI_CLK_O !== 1'b0; j++)
				tick();
			flash_miso = img[i];
			for (j = 0; j < 40 && SPI_CLK_O !== 1'b1; j++)
				tick();
			guard(SPI_CLK_O);
		end
		tick(6);
		flash_miso = ~flash_miso;
		tick(4);
		chk({PROG_DONE, PROG_REJECT, PROG_BUSY, SPI_SS_N_OE}, {done, 3'h0},
			"flash image");
		chk(got.size(), done, "image bytes");
		if (done)
			chk(got[0], 8'h5A, "image data");
		chk(USER_SPI_MISO, flash_miso, "data-in follows");
	endtask
	// Main sequence
	initial
	begin
		t_jtag();
		t_fifo();
		t_slave();
		t_susp();
		t_tamper();
		t_master(5'h14, 32'h0300_1000, 24'h81_015A, 24,
			1'b1);
		t_master(5'h12, 32'h0310_0000, 24'h81_015A, 24,
			1'b1);
		t_master(5'h11, 32'h0300_1000, 24'h86_015A, 24,
			1'b1);
		t_master(5'h11, 32'h0300_1000, 24'h00_0083, 8,
			1'b0);
		complete_run();
	end
endmodule // config_programming_control_tb
bind config_programming_control config_programming_control_asserts
	u_config_programming_control_asserts (.SYS_CLK, .RESET_N, .SPI_TRISTATE,
	.SPI_CLK_OE, .SPI_SS_N_OE, .SPI_MOSI_OE, .SPI_MISO_OE, .USER_SPI_GRANT,
	.JTAG_TRST_N, .JTAG_READY, .SUSPEND_ACTIVE, .CTRL_HALTED, .PROG_VALID,
	.PROG_READY, .PROG_DATA, .DIGEST_FAIL, .DIGEST_CLEAR, .DIGEST_TAMPER);
`default_nettype wire
